// ---- hw/crs_pkg.sv ----
package crs_pkg;

    // =========================================================
    // timing
    // =========================================================
    localparam int  CLK_HZ           = 50_000_000;
    localparam int  REGULATOR_INPUT_SUPPLY_SETTLE_MS   = 8;
    localparam int  ANA_SETTLE_MS    = 4;
    localparam int  REGULATOR_INPUT_SUPPLY_SETTLE_CYC  = REGULATOR_INPUT_SUPPLY_SETTLE_MS * (CLK_HZ / 1000);
    localparam int  ANA_SETTLE_CYC   = ANA_SETTLE_MS * (CLK_HZ / 1000);
    localparam int  RESET_LOW_MIN_P  = 3;
    localparam int  BOOT_DELAY_CYC   = 38;

    // =========================================================
    // core voltage thresholds, millivolts
    // =========================================================
    localparam int  VCORE_W          = 12;
    localparam logic [VCORE_W-1:0] VCORE_RISE_MV = 12'h3b6;
    localparam logic [VCORE_W-1:0] VCORE_FALL_MV = 12'h352;

    // =========================================================
    // pin group widths and levels
    // =========================================================
    localparam int  HIGH_GROUP_W     = 11;
    localparam int  LOW_GROUP_W      = 5;
    localparam int  Z_GROUP_W        = 16;
    localparam int  MEM_DATA_W       = 16;
    localparam int  MEM_ADDR_W       = 21;
    localparam int  MEM_BANK_W       = 2;
    localparam int  SEL_W            = 16;
    localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;

    typedef enum logic [2:0] {
        CRS_RESET   = 3'b001,
        CRS_RELEASE = 3'b010,
        CRS_RUN     = 3'b100
    } crs_state_type;

endpackage : crs_pkg

// ---- hw/crs_settle_timer.sv ----
`timescale 1ns/1ps
module crs_settle_timer #(
    parameter int COUNT = 4
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    // supply status
    input  wire logic supply_up,
    output logic      settled
);
    localparam int CW = $clog2(COUNT + 1);

    initial begin
        if (COUNT < 1) $error("crs_settle_timer: COUNT must be at least 1");
    end

    logic [CW-1:0] count;
    wire           done = (count == CW'(COUNT));

    // =========================================================
    // counts up while supply holds, restarts on loss
    // =========================================================
    always_ff @(posedge clk) begin
        if (reset || !supply_up) begin
            count <= '0;
        end else if (clk_en && !done) begin
            count <= count + CW'(1);
        end
    end

    assign settled = done;
endmodule : crs_settle_timer

// ---- hw/crs_reset_ctrl.sv ----
`timescale 1ns/1ps
// What this block does
// - global reset is reset pin and power_ok
// - power_ok waits 8ms, 4ms, 950mV
// - after power_ok, threshold drops to 850mV
// - regulator disabled forces power_ok high
// - global reset spares rtc domain
// - rtc power-on clears power-lost flag
// - reset release enables clock, starts boot
// - outside reset, select register gates z group drivers
// - high group driven high in reset
// - low group driven low in reset
// - z group high impedance in reset
// - clock output pins follow clock behaviour
// - cs0, cs2, clock enable rise after release
// - memory cs0, cs1 fall after release
// - bank address, flag settle high
// - address bus settles low
// - cpu and peripheral software resets supported
module crs_reset_ctrl
    import crs_pkg::*;
#(
    parameter int REGULATOR_INPUT_SUPPLY_CYC = REGULATOR_INPUT_SUPPLY_SETTLE_CYC,
    parameter int ANA_CYC  = ANA_SETTLE_CYC,
    parameter int BOOT_CYC = BOOT_DELAY_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    // board and supply inputs
    input  wire logic                    reset_pin_n,
    input  wire logic                    core_regulator_disable_pin,
    input  wire logic                    regulator_input_supply,
    input  wire logic                    analog_supply,
    input  wire logic [VCORE_W-1:0]      core_regulator_output,
    // rtc domain
    input  wire logic                    rtc_por,
    input  wire logic                    rtc_time_set,
    output logic                         rtc_power_lost_flag,
    // software resets
    input  wire logic                    cpu_soft_reset,
    input  wire logic                    periph_soft_reset_req,
    output logic                         cpu_reset_n,
    output logic                         periph_reset_n,
    // status
    output logic                         power_ok,
    output logic                         global_reset_n,
    output logic                         sysclk_gen_en,
    output logic                         boot_start,
    // pin selection and peripheral side
    input  wire logic [SEL_W-1:0]        external_bus_select_reg,
    input  wire logic [HIGH_GROUP_W-1:0] per_high_o,
    input  wire logic [LOW_GROUP_W-1:0]  per_low_o,
    input  wire logic [Z_GROUP_W-1:0]    per_z_o,
    input  wire logic [Z_GROUP_W-1:0]    per_z_oe,
    input  wire logic [MEM_DATA_W-1:0]   per_mem_data_o,
    input  wire logic                    per_mem_data_oe,
    input  wire logic [MEM_ADDR_W-1:0]   per_mem_address_bus,
    input  wire logic [MEM_BANK_W-1:0]   per_mem_bank_address,
    input  wire logic [1:0]              per_mem_chip_select,
    input  wire logic [2:0]              per_sync_high,
    input  wire logic                    per_external_flag_out,
    input  wire logic                    clock_source,
    // pins
    output logic [HIGH_GROUP_W-1:0]      high_group_pins,
    output logic [LOW_GROUP_W-1:0]       low_group_pins,
    output logic [Z_GROUP_W-1:0]         z_group_o,
    output logic [Z_GROUP_W-1:0]         z_group_oe,
    output logic [MEM_DATA_W-1:0]        mem_data_o,
    output logic                         mem_data_oe,
    output logic                         clock_output_pin,
    output logic                         serial_cs1,
    output logic [2:0]                   sync_rise_pins,
    output logic [1:0]                   mem_chip_select,
    output logic [MEM_BANK_W-1:0]        mem_bank_address,
    output logic                         external_flag_out,
    output logic [MEM_ADDR_W-1:0]        mem_address_bus
);
    localparam int BW = $clog2(BOOT_CYC + 1);

    initial begin
        if (BOOT_CYC < 1) $error("crs_reset_ctrl: BOOT_CYC must be at least 1");
        if (REGULATOR_INPUT_SUPPLY_CYC < 1 || ANA_CYC < 1) $error("crs_reset_ctrl: settle counts below 1");
        // the select word must cover every z group pin
        if (SEL_W < Z_GROUP_W) $error("crs_reset_ctrl: SEL_W narrower than z group");
    end

    // =========================================================
    // supply settle timers
    // =========================================================
    logic regulator_input_supply_settled;
    logic ana_settled;

    crs_settle_timer #(.COUNT(REGULATOR_INPUT_SUPPLY_CYC)) u_regulator_input_supply_timer (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .supply_up (regulator_input_supply),
        .settled   (regulator_input_supply_settled)
    );

    crs_settle_timer #(.COUNT(ANA_CYC)) u_ana_timer (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .supply_up (analog_supply),
        .settled   (ana_settled)
    );

    // =========================================================
    // power monitor with hysteresis
    // =========================================================
    logic monitor_ok;
    wire  vcore_above_rise = core_regulator_output > VCORE_RISE_MV;
    wire  vcore_above_fall = core_regulator_output > VCORE_FALL_MV;
    // once up, the lower threshold keeps power_ok
    wire  vcore_ok         = monitor_ok ? vcore_above_fall : vcore_above_rise;
    wire  next_monitor_ok = regulator_input_supply_settled && ana_settled && vcore_ok;

    always_ff @(posedge clk) begin
        if (reset) begin
            monitor_ok <= 1'b0;
        end else if (clk_en) begin
            monitor_ok <= next_monitor_ok;
        end
    end

    // disabled regulator bypasses the monitor at once
    assign power_ok = core_regulator_disable_pin | monitor_ok;

    // =========================================================
    // global reset combine and synchronous release
    // =========================================================
    wire  raw_reset_n = reset_pin_n & power_ok;
    logic rst_sync1;
    logic rst_sync2;

    // the board keeps the pin low three clocks; assertion acts at the next clock edge, even with clk_en low
    always_ff @(posedge clk) begin
        if (reset || !raw_reset_n) begin
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end else if (clk_en) begin
            rst_sync1 <= 1'b1;
            rst_sync2 <= rst_sync1;
        end
    end

    wire in_reset = !rst_sync2;
    assign global_reset_n = rst_sync2;

    // =========================================================
    // release sequencer
    // =========================================================
    crs_state_type state;
    crs_state_type next_state;
    logic [BW-1:0] boot_count;
    wire           boot_done = (boot_count == BW'(BOOT_CYC));
    wire           count_boot = (state == CRS_RELEASE) && !boot_done;

    always_comb begin
        next_state = state;
        unique case (state)
            CRS_RESET:   next_state = CRS_RELEASE;
            CRS_RELEASE: if (boot_done) next_state = CRS_RUN;
            CRS_RUN:     next_state = CRS_RUN;
            default:     next_state = CRS_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            state <= CRS_RESET;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // boot delay counter runs only while releasing
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            boot_count <= '0;
        end else if (clk_en && count_boot) begin
            boot_count <= boot_count + BW'(1);
        end
    end

    assign sysclk_gen_en = !in_reset;
    assign boot_start    = (state == CRS_RELEASE) && boot_done;

    // =========================================================
    // software resets
    // =========================================================
    assign cpu_reset_n    = global_reset_n & ~cpu_soft_reset;
    assign periph_reset_n = global_reset_n & ~periph_soft_reset_req;

    // =========================================================
    // rtc power-lost flag, rtc power-on reset only
    // =========================================================
    always_ff @(posedge clk) begin
        if (rtc_por) begin
            rtc_power_lost_flag <= 1'b0;
        end else if (clk_en && rtc_time_set) begin
            rtc_power_lost_flag <= 1'b1;
        end
    end

    // =========================================================
    // pin selection
    // =========================================================
    logic [SEL_W-1:0] sel_q;

    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            sel_q <= SEL_RESET;
        end else if (clk_en) begin
            sel_q <= external_bus_select_reg;
        end
    end

    // selection word gates whether peripherals drive the z group
    wire [Z_GROUP_W-1:0] z_enable = per_z_oe & sel_q[Z_GROUP_W-1:0];

    // =========================================================
    // asynchronous pin groups
    // =========================================================
    // fixed levels while in reset
    assign high_group_pins = in_reset ? '1 : per_high_o;
    assign low_group_pins  = in_reset ? '0 : per_low_o;
    // z group and data bus: drivers off in reset
    assign z_group_o       = in_reset ? '0 : per_z_o;
    assign z_group_oe      = in_reset ? '0 : z_enable;
    assign mem_data_o      = in_reset ? '0 : per_mem_data_o;
    assign mem_data_oe     = in_reset ? 1'b0 : per_mem_data_oe;

    // clock output keeps clocking through reset
    assign clock_output_pin = clock_source;
    assign serial_cs1       = clock_source;

    // =========================================================
    // synchronous pin groups
    // =========================================================
    // serial cs0, cs2 and clock enable: low, then rise
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            sync_rise_pins <= '0;
        end else if (clk_en) begin
            sync_rise_pins <= per_sync_high;
        end
    end

    // memory cs0 and cs1: high, then fall
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            mem_chip_select <= '1;
        end else if (clk_en) begin
            mem_chip_select <= per_mem_chip_select;
        end
    end

    // bank address settles high
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            mem_bank_address <= '1;
        end else if (clk_en) begin
            mem_bank_address <= per_mem_bank_address;
        end
    end

    // flag output settles high
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            external_flag_out <= 1'b1;
        end else if (clk_en) begin
            external_flag_out <= per_external_flag_out;
        end
    end

    // address bus settles low
    always_ff @(posedge clk) begin
        if (reset || in_reset) begin
            mem_address_bus <= '0;
        end else if (clk_en) begin
            mem_address_bus <= per_mem_address_bus;
        end
    end
endmodule : crs_reset_ctrl

// ---- test/crs_board_model.sv ----
`timescale 1ns/1ps
module crs_board_model (
    // board reset pin
    input  wire logic clk,
    output logic      reset_pin_n
);
    // board holds the pin low from power-up
    initial reset_pin_n = 1'b0;
    task automatic pulse(input int n);
        int len;
        len = (n < 3) ? 3 : n;
        @(posedge clk);
        #1 reset_pin_n = 1'b0;
        repeat (len) @(posedge clk);
        #1 reset_pin_n = 1'b1;
    endtask : pulse
endmodule : crs_board_model

// ---- test/crs_monitor.sv ----
`timescale 1ns/1ps
module crs_monitor
    import crs_pkg::*;
#(parameter int BOOT_CYC = BOOT_DELAY_CYC)
(
    // clock, reset and inputs
    input wire logic clk, reset, clk_en, reset_pin_n, core_regulator_disable_pin,
    input wire logic rtc_por, clock_source,
    input wire logic [VCORE_W-1:0] core_regulator_output,
    // outputs
    input wire logic power_ok, global_reset_n, sysclk_gen_en, boot_start, rtc_power_lost_flag,
    input wire logic mem_data_oe, clock_output_pin, serial_cs1,
    input wire logic [HIGH_GROUP_W-1:0] high_group_pins,
    input wire logic [LOW_GROUP_W-1:0] low_group_pins,
    input wire logic [Z_GROUP_W-1:0] z_group_oe,
    input wire logic [2:0] sync_rise_pins,
    input wire logic [1:0] mem_chip_select,
    input wire logic [MEM_ADDR_W-1:0] mem_address_bus
);
    localparam int BT = BOOT_CYC;
    wire raw_n = reset_pin_n && power_ok;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_and; clk_en && !raw_n |=> !global_reset_n; endproperty
    a_and: assert property (p_and) else $error("reset not taken");
    property p_hys; clk_en && !core_regulator_disable_pin && core_regulator_output <= VCORE_FALL_MV
        |=> !power_ok; endproperty
    a_hys: assert property (p_hys) else $error("power ok held too low");
    property p_off; core_regulator_disable_pin |-> power_ok; endproperty
    a_off: assert property (p_off) else $error("power ok not forced");
    property p_rtc; rtc_por |=> !rtc_power_lost_flag; endproperty
    a_rtc: assert property (p_rtc) else $error("flag not cleared");
    property p_clk; sysclk_gen_en == global_reset_n; endproperty
    a_clk: assert property (p_clk) else $error("clock enable wrong");
    property p_boot; $rose(global_reset_n) |-> ##BT !boot_start ##1
        (boot_start || !global_reset_n); endproperty
    a_boot: assert property (p_boot) else $error("boot start late or early");
    property p_hi; !global_reset_n |-> high_group_pins == 11'h7ff && low_group_pins == 5'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("fixed groups wrong");
    property p_z; !global_reset_n |-> !mem_data_oe && z_group_oe == 16'h0; endproperty
    a_z: assert property (p_z) else $error("z group driven");
    property p_co; clock_output_pin == clock_source && serial_cs1 == clock_source; endproperty
    a_co: assert property (p_co) else $error("clock out wrong");
    property p_syn; clk_en && !global_reset_n |=> sync_rise_pins == 3'h0
        && mem_chip_select == 2'h3 && mem_address_bus == 21'h0; endproperty
    a_syn: assert property (p_syn) else $error("sync groups wrong");
    property p_rel; $rose(global_reset_n) |-> $past(raw_n, 2) && $past(raw_n); endproperty
    a_rel: assert property (p_rel) else $error("release not synced");
    c_rel: cover property ($rose(global_reset_n));
    c_pok: cover property ($fell(power_ok));
    c_rtc: cover property (rtc_por ##1 !rtc_power_lost_flag);
endmodule : crs_monitor
bind crs_reset_ctrl crs_monitor #(.BOOT_CYC(BOOT_CYC)) u_mon (.*);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import crs_pkg::*;
;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
    // =========================================
    // signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en, core_regulator_disable_pin, regulator_input_supply, analog_supply;
    logic rtc_por, rtc_time_set, cpu_soft_reset, periph_soft_reset_req, per_mem_data_oe;
    logic per_external_flag_out, rtc_power_lost_flag, cpu_reset_n, periph_reset_n;
    logic power_ok, global_reset_n, sysclk_gen_en, boot_start;
    logic mem_data_oe, clock_output_pin, serial_cs1, external_flag_out;
    logic [VCORE_W-1:0] core_regulator_output;
    logic [SEL_W-1:0] external_bus_select_reg;
    logic [HIGH_GROUP_W-1:0] per_high_o, high_group_pins;
    logic [LOW_GROUP_W-1:0] per_low_o, low_group_pins;
    logic [Z_GROUP_W-1:0] per_z_o, per_z_oe, z_group_o, z_group_oe;
    logic [MEM_DATA_W-1:0] per_mem_data_o, mem_data_o;
    logic [MEM_ADDR_W-1:0] per_mem_address_bus, mem_address_bus;
    logic [MEM_BANK_W-1:0] per_mem_bank_address, mem_bank_address;
    logic [1:0] per_mem_chip_select, mem_chip_select;
    logic [2:0] per_sync_high, sync_rise_pins;
    wire reset_pin_n;
    wire clock_source = clk;
    int num_errors = 0;
    int tests_run = 0;
    crs_reset_ctrl #(.REGULATOR_INPUT_SUPPLY_CYC(10), .ANA_CYC(5), .BOOT_CYC(4)) u_dut (.*);
    crs_board_model u_board (.clk(clk), .reset_pin_n(reset_pin_n));
    initial begin
        forever #10 clk = ~clk;
    end
    // =========================================
    // helpers
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    function automatic logic pick(input int k);
        return (k == 0) ? power_ok : (k == 1) ? global_reset_n : boot_start;
    endfunction : pick
    task automatic wait_hi(input int k, input int lim, output int n);
        n = 0;
        while (pick(k) !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        if (pick(k) !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_hi
    task automatic check_pins(input bit held);
        if (held) begin
            `CHK({high_group_pins, low_group_pins}, 16'hffe0)
            `CHK({z_group_oe, mem_data_oe}, 17'h0)
            `CHK({sync_rise_pins, mem_chip_select}, 5'h03)
            `CHK({mem_bank_address, external_flag_out}, 3'h7)
            `CHK(mem_address_bus, 21'h0)
        end else begin
            `CHK({high_group_pins, low_group_pins}, {per_high_o, per_low_o})
            `CHK(z_group_oe, per_z_oe & external_bus_select_reg)
            `CHK({sync_rise_pins, mem_chip_select}, {per_sync_high, per_mem_chip_select})
            `CHK(mem_bank_address, per_mem_bank_address)
            `CHK(mem_address_bus, per_mem_address_bus)
            `CHK({z_group_o, mem_data_o, mem_data_oe}, {per_z_o, per_mem_data_o, per_mem_data_oe})
            `CHK(external_flag_out, per_external_flag_out)
        end
        `CHK(clock_output_pin, clock_source)
        `CHK(serial_cs1, clock_source)
    endtask : check_pins
    // =========================================
    // scenarios
    task automatic power_up();
        int n;
        regulator_input_supply = 1'b1;
        analog_supply = 1'b1;
        core_regulator_output = 12'h3e8;
        wait_hi(0, 60, n);
        `CHK(n >= 10, 1'b1)
        core_regulator_output = 12'h384;
        cyc(3);
        `CHK(power_ok, 1'b1)
        core_regulator_output = 12'h352;
        cyc(2);
        `CHK(power_ok, 1'b0)
        core_regulator_output = 12'h3b6;
        cyc(15);
        `CHK({power_ok, global_reset_n}, 2'b00)
        core_regulator_output = 12'h3b7;
        wait_hi(1, 10, n);
        `CHK(sysclk_gen_en, 1'b1)
        cyc(2);
        check_pins(0);
        wait_hi(2, 20, n);
    endtask : power_up
    task automatic freeze();
        clk_en = 1'b0;
        per_mem_address_bus = 21'h0aaaa;
        cyc(3);
        `CHK(mem_address_bus, 21'h15555)
        clk_en = 1'b1;
        cyc(1);
        `CHK(mem_address_bus, 21'h0aaaa)
    endtask : freeze
    task automatic pin_reset();
        int n;
        fork
            u_board.pulse(3);
        join_none
        cyc(3);
        `CHK(global_reset_n, 1'b0)
        check_pins(1);
        wait_hi(1, 10, n);
        `CHK(boot_start, 1'b0)
        wait_hi(2, 20, n);
    endtask : pin_reset
    task automatic rtc_soft();
        rtc_time_set = 1'b1;
        cyc(1);
        rtc_time_set = 1'b0;
        pin_reset();
        `CHK(rtc_power_lost_flag, 1'b1)
        rtc_por = 1'b1;
        cyc(1);
        rtc_por = 1'b0;
        `CHK(rtc_power_lost_flag, 1'b0)
        cpu_soft_reset = 1'b1;
        #1;
        `CHK({cpu_reset_n, periph_reset_n, global_reset_n}, 3'b011)
        cpu_soft_reset = 1'b0;
        periph_soft_reset_req = 1'b1;
        #1;
        `CHK({cpu_reset_n, periph_reset_n, global_reset_n}, 3'b101)
        periph_soft_reset_req = 1'b0;
    endtask : rtc_soft
    task automatic reg_off();
        core_regulator_disable_pin = 1'b1;
        regulator_input_supply = 1'b0;
        core_regulator_output = 12'h000;
        #1;
        `CHK(power_ok, 1'b1)
        cyc(3);
        `CHK(global_reset_n, 1'b1)
        pin_reset();
    endtask : reg_off
    initial begin
        {clk_en, core_regulator_disable_pin, regulator_input_supply, analog_supply} = 4'h8;
        {rtc_por, rtc_time_set, cpu_soft_reset, periph_soft_reset_req} = 4'h0;
        core_regulator_output = 12'h000;
        external_bus_select_reg = 16'h00ff;
        {per_high_o, per_low_o, per_z_oe, per_z_o} = {11'h000, 5'h1f, 16'hffff, 16'ha5a5};
        {per_mem_data_o, per_mem_data_oe, per_mem_address_bus} = {16'h1234, 1'b1, 21'h15555};
        {per_mem_bank_address, per_mem_chip_select, per_sync_high} = {2'h1, 2'h0, 3'h7};
        per_external_flag_out = 1'b0;
        cyc(6);
        reset = 1'b0;
        fork
            u_board.pulse(3);
        join_none
        cyc(6);
        check_pins(1);
        power_up();
        freeze();
        pin_reset();
        rtc_soft();
        reg_off();
        report_and_stop();
    end
endmodule : testbench
